//--- design/rfa_pkg.sv
// Package of constants and carriers for the general-purpose register file and its address logic.
package rfa_pkg;

   // ----------------------------------------------------------------
   // Register number space
   // ----------------------------------------------------------------
   localparam int REG_NUM_W = 8;
   localparam int DATA_W = 32;
   localparam int SP_FIELD_W = 7;
   localparam logic [7:0] GR_INDIRECT = 8'h00;
   localparam logic [7:0] GR_STACK_PTR = 8'h01;
   localparam logic [7:0] GR_IMPL_LO = 8'h40;
   localparam logic [7:0] GR_LOCAL_LO = 8'h80;
   localparam int SP_FIELD_LSB = 2;
   localparam int SP_FIELD_MSB = 8;
   localparam int BANK_LSB = 4;

   // ----------------------------------------------------------------
   // Special-purpose register numbers
   // ----------------------------------------------------------------
   localparam logic [7:0] SPR_VECTOR_BASE = 8'h00;
   localparam logic [7:0] SPR_SAVED_PROCESSOR_STATUS = 8'h01;
   localparam logic [7:0] SPR_CURRENT_PROCESSOR_STATUS = 8'h02;
   localparam logic [7:0] SPR_CONFIGURATION = 8'h03;
   localparam logic [7:0] SPR_CHANNEL_ADDRESS = 8'h04;
   localparam logic [7:0] SPR_CHANNEL_DATA = 8'h05;
   localparam logic [7:0] SPR_CHANNEL_CONTROL = 8'h06;
   localparam logic [7:0] SPR_REGISTER_BANK_PROTECT = 8'h07;
   localparam logic [7:0] SPR_TIMER_COUNT = 8'h08;
   localparam logic [7:0] SPR_TIMER_RELOAD = 8'h09;
   localparam logic [7:0] SPR_PROGRAM_COUNTER_0 = 8'h0a;
   localparam logic [7:0] SPR_PROGRAM_COUNTER_1 = 8'h0b;
   localparam logic [7:0] SPR_PROGRAM_COUNTER_2 = 8'h0c;
   localparam logic [7:0] SPR_INDIRECT_PTR_RESULT = 8'h80;
   localparam logic [7:0] SPR_INDIRECT_PTR_SRC_A = 8'h81;
   localparam logic [7:0] SPR_INDIRECT_PTR_SRC_B = 8'h82;
   localparam logic [7:0] SPR_MUL_DIV_EXTENSION = 8'h83;
   localparam logic [7:0] SPR_ARITH_STATUS = 8'h84;
   localparam logic [7:0] SPR_BYTE_POINTER = 8'h85;
   localparam logic [7:0] SPR_FUNNEL_SHIFT_COUNT = 8'h86;
   localparam logic [7:0] SPR_LOAD_STORE_REMAINING = 8'h87;
   localparam logic [7:0] SPR_FLOAT_ENVIRONMENT = 8'ha0;
   localparam logic [7:0] SPR_DIV_ENVIRONMENT = 8'ha1;
   localparam logic [7:0] SPR_FLOAT_STATUS = 8'ha2;
   localparam logic [7:0] SPR_UNPROT_LO = 8'h80;
   localparam logic [7:0] SPR_UNPROT_HI = 8'h9f;
   localparam logic [7:0] SPR_VIRTUAL_LO = 8'ha0;

   // ----------------------------------------------------------------
   // Field layouts and reset values
   // ----------------------------------------------------------------
   localparam int IPTR_FIELD_LSB = 2;
   localparam int IPTR_FIELD_MSB = 9;
   localparam int NUM_IPTR = 3;
   localparam int IPTR_RESULT = 0;
   localparam int IPTR_SRC_A = 1;
   localparam int IPTR_SRC_B = 2;
   localparam int SPR_STORE_DEPTH = 18;
   localparam logic [31:0] SPR_RESET = 32'h0000_0000;
   localparam logic [7:0] IPTR_RESET = 8'h00;
   localparam logic [6:0] SP_RESET = 7'h00;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] src_a;
      logic [7:0] src_b;
      logic [7:0] dst;
   } rfa_fields_t;

   typedef struct packed {
      logic wr;
      logic [7:0] num;
      logic [31:0] data;
   } rfa_spr_req_t;

endpackage

//--- design/rfa_regfile.sv
// General-purpose register file with register number translation and special register protection.
// ----------------------------------------------------------------
// Overview of operation
// (RULE1) 64 global and 128 local registers; number bit 7 picks local group.
// (RULE2) Top bit zero: global register, absolute number equals register number.
// (RULE3) Globals 2-63 hold nothing; user access may be blocked by bank protect.
// (RULE4) Global 0 takes the number from that field's own indirect pointer.
// (RULE5) Global register 1 holds the stack pointer used for local translation.
// (RULE6) Local: add seven-bit number to stack pointer bits 8-2, keep bit 7 set.
// (RULE7) Hidden stack pointer copy updates only from arithmetic or logical results.
// (RULE8) Stack pointer change reaches local translation only after a pipeline delay.
// (RULE9) Two source fields and one destination field, each direct or indirect.
// (RULE10) Twenty-four special registers reached only by explicit move requests.
// (RULE11) Hardware may change special registers, so reads need not echo writes.
// (RULE12) Reserved special register bits read zero; writing ones does nothing.
// (RULE13) Special register chosen directly by its 8-bit number, never indirectly.
// (RULE14) Special numbers 0-127 and 160-255 protected, 128-159 unprotected.
// (RULE15) User access to special numbers 0-127 traps instead of accessing.
// (RULE16) Any access to special numbers 160-255 traps in either mode.
// (RULE17) Float environment, divide environment and float status have no storage.
// (RULE18) Unimplemented special reads give undefined data; unprotected writes do nothing.
// (RULE19) Move to indirect pointer loads source bits 9-2, effective after a delay.
// (RULE20) Two read ports and one write port each cycle on absolute numbers.
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module rfa_regfile (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic sys_rst,
   // Operand resolution and read request from the decoder.
   input wire logic rd_valid,
   input wire rfa_pkg::rfa_fields_t fields,
   input wire logic user_mode,
   // Result write port on an absolute register number.
   input wire logic wr_en,
   input wire logic [7:0] wr_abs,
   input wire logic [31:0] wr_data,
   input wire logic wr_arith,
   // Hardware load of all three indirect pointers.
   input wire logic ip_set,
   input wire rfa_pkg::rfa_fields_t ip_vals,
   // Special register move request.
   input wire logic spr_valid,
   input wire rfa_pkg::rfa_spr_req_t spr_req,
   // Resolved operand numbers and read data.
   output rfa_pkg::rfa_fields_t abs_r,
   output logic [31:0] rdata_a_r,
   output logic [31:0] rdata_b_r,
   output logic bank_trap_r,
   // Special register answer.
   output logic spr_ack_r,
   output logic [31:0] spr_rdata_r,
   output logic prot_trap_r
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [31:0] gpr_mem [64:255];
   logic [31:0] stack_ptr_r;
   logic [6:0] shadow_sp_r;
   logic [6:0] sp_eff_r;
   logic [31:0] spr_mem [0:rfa_pkg::SPR_STORE_DEPTH-1];
   logic [7:0] iptr_r [rfa_pkg::NUM_IPTR];
   logic [7:0] iptr_eff_r [rfa_pkg::NUM_IPTR];
   logic [7:0] res_a;
   logic [7:0] res_b;
   logic [7:0] res_c;
   logic spr_hit;
   logic [4:0] spr_idx;
   logic is_iptr;
   logic [1:0] iptr_sel;
   logic trap_now;
   logic [15:0] bank_prot;

   // Resolve one 8-bit field into an absolute register number.
   function automatic logic [7:0] resolve(input logic [7:0] num, input logic [7:0] ptr,
                                          input logic [6:0] sp);
      logic [7:0] abs_num;
      abs_num = num;
      if (num == rfa_pkg::GR_INDIRECT) begin
         abs_num = ptr; // [RULE4]
      end else if (num[7]) begin
         abs_num = {1'b1, 7'(num[6:0] + sp)}; // [RULE6] [RULE1]
      end
      return abs_num; // [RULE2]
   endfunction

   // Read one general register by absolute number; unbacked globals read zero.
   function automatic logic [31:0] gpr_read(input logic [7:0] abs_num,
                                            input logic [31:0] sp_word);
      logic [31:0] val;
      val = 32'h0000_0000;
      if (abs_num >= rfa_pkg::GR_IMPL_LO) begin
         val = gpr_mem[abs_num];
      end else if (abs_num == rfa_pkg::GR_STACK_PTR) begin
         val = sp_word; // [RULE5]
      end
      return val; // [RULE3]
   endfunction

   // ----------------------------------------------------------------
   // Operand resolution
   // ----------------------------------------------------------------
   // Each field is resolved on its own against its own delayed pointer.
   always_comb begin
      res_a = resolve(fields.src_a, iptr_eff_r[rfa_pkg::IPTR_SRC_A], sp_eff_r); // [RULE9]
      res_b = resolve(fields.src_b, iptr_eff_r[rfa_pkg::IPTR_SRC_B], sp_eff_r); // [RULE9]
      res_c = resolve(fields.dst, iptr_eff_r[rfa_pkg::IPTR_RESULT], sp_eff_r); // [RULE9]
   end

   // Bank protect bits are taken from the low half of the bank protect register.
   always_comb begin
      bank_prot = spr_mem[rfa_pkg::SPR_REGISTER_BANK_PROTECT[4:0]][15:0];
   end

   // Register the resolved numbers and both read ports.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         abs_r <= '0;
         rdata_a_r <= 32'h0000_0000;
         rdata_b_r <= 32'h0000_0000;
      end else if (rd_valid) begin
         abs_r.src_a <= res_a;
         abs_r.src_b <= res_b;
         abs_r.dst <= res_c;
         rdata_a_r <= gpr_read(res_a, stack_ptr_r); // [RULE20]
         rdata_b_r <= gpr_read(res_b, stack_ptr_r); // [RULE20]
      end
   end

   // User-mode access to a protected bank, including the unbacked globals.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         bank_trap_r <= 1'b0;
      end else begin
         bank_trap_r <= rd_valid && user_mode &&
                        (bank_prot[res_a[7:rfa_pkg::BANK_LSB]] ||
                         bank_prot[res_b[7:rfa_pkg::BANK_LSB]] ||
                         bank_prot[res_c[7:rfa_pkg::BANK_LSB]]); // [RULE3]
      end
   end

   // ----------------------------------------------------------------
   // Write port and stack pointer
   // ----------------------------------------------------------------
   // Backed registers take the write; unbacked globals drop it.
   always_ff @(posedge core_clk) begin
      if (wr_en && wr_abs >= rfa_pkg::GR_IMPL_LO) begin
         gpr_mem[wr_abs] <= wr_data; // [RULE20] [RULE1]
      end
   end

   // Global register 1 itself takes any write.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         stack_ptr_r <= rfa_pkg::SPR_RESET;
      end else if (wr_en && wr_abs == rfa_pkg::GR_STACK_PTR) begin
         stack_ptr_r <= wr_data; // [RULE5]
      end
   end

   // The hidden copy only follows arithmetic or logical results.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         shadow_sp_r <= rfa_pkg::SP_RESET;
      end else if (wr_en && wr_arith && wr_abs == rfa_pkg::GR_STACK_PTR) begin
         shadow_sp_r <= wr_data[rfa_pkg::SP_FIELD_MSB:rfa_pkg::SP_FIELD_LSB]; // [RULE7]
      end
   end

   // One extra stage before translation sees the new base.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sp_eff_r <= rfa_pkg::SP_RESET;
      end else begin
         sp_eff_r <= shadow_sp_r; // [RULE8]
      end
   end

   // ----------------------------------------------------------------
   // Special register decode
   // ----------------------------------------------------------------
   // Map a number onto backed storage; pointers and virtual numbers are not backed here.
   always_comb begin
      spr_hit = 1'b0;
      spr_idx = 5'h00;
      is_iptr = 1'b0;
      iptr_sel = 2'h0;
      if (spr_req.num <= rfa_pkg::SPR_PROGRAM_COUNTER_2) begin
         spr_hit = 1'b1;
         spr_idx = spr_req.num[4:0]; // [RULE13]
      end else if (spr_req.num >= rfa_pkg::SPR_MUL_DIV_EXTENSION &&
                   spr_req.num <= rfa_pkg::SPR_LOAD_STORE_REMAINING) begin
         spr_hit = 1'b1;
         spr_idx = 5'(spr_req.num - rfa_pkg::SPR_MUL_DIV_EXTENSION + 8'd13); // [RULE10]
      end else if (spr_req.num >= rfa_pkg::SPR_INDIRECT_PTR_RESULT &&
                   spr_req.num <= rfa_pkg::SPR_INDIRECT_PTR_SRC_B) begin
         is_iptr = 1'b1;
         iptr_sel = spr_req.num[1:0];
      end
   end

   // Virtual numbers always trap; low numbers trap in user mode.
   always_comb begin
      trap_now = spr_valid &&
                 ((spr_req.num >= rfa_pkg::SPR_VIRTUAL_LO) || // [RULE16] [RULE17]
                  (user_mode && spr_req.num < rfa_pkg::SPR_UNPROT_LO)); // [RULE15] [RULE14]
   end

   // Backed special registers; a trapped or unbacked write changes nothing.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < rfa_pkg::SPR_STORE_DEPTH; i++) begin
            spr_mem[i] <= rfa_pkg::SPR_RESET;
         end
      end else if (spr_valid && spr_req.wr && spr_hit && !trap_now) begin
         spr_mem[spr_idx] <= spr_req.data; // [RULE18] [RULE10]
      end
   end

   // Indirect pointers, each with a delayed copy used for resolution.
   for (genvar g = 0; g < rfa_pkg::NUM_IPTR; g++) begin : g_iptr
      logic [7:0] hw_val;
      assign hw_val = (g == rfa_pkg::IPTR_RESULT) ? ip_vals.dst :
                      (g == rfa_pkg::IPTR_SRC_A) ? ip_vals.src_a : ip_vals.src_b;
      // Hardware load wins over a software move in the same cycle.
      always_ff @(posedge core_clk) begin
         if (sys_rst) begin
            iptr_r[g] <= rfa_pkg::IPTR_RESET;
         end else if (ip_set) begin
            iptr_r[g] <= hw_val; // [RULE11]
         end else if (spr_valid && spr_req.wr && is_iptr && iptr_sel == 2'(g)) begin
            iptr_r[g] <= spr_req.data[rfa_pkg::IPTR_FIELD_MSB:rfa_pkg::IPTR_FIELD_LSB]; // [RULE19]
         end
      end
      // The delayed copy gives the documented late effect of a move.
      always_ff @(posedge core_clk) begin
         if (sys_rst) begin
            iptr_eff_r[g] <= rfa_pkg::IPTR_RESET;
         end else begin
            iptr_eff_r[g] <= iptr_r[g]; // [RULE19]
         end
      end
   end

   // Answer every move request one cycle later with data or a trap.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         spr_ack_r <= 1'b0;
         prot_trap_r <= 1'b0;
         spr_rdata_r <= 32'h0000_0000;
      end else begin
         spr_ack_r <= spr_valid;
         prot_trap_r <= trap_now; // [RULE14]
         if (!spr_valid || trap_now) begin
            spr_rdata_r <= 32'h0000_0000;
         end else if (spr_hit) begin
            spr_rdata_r <= spr_mem[spr_idx];
         end else if (is_iptr) begin
            spr_rdata_r <= {22'h00_0000, iptr_r[iptr_sel], 2'b00}; // [RULE12]
         end else begin
            spr_rdata_r <= 32'h0000_0000; // [RULE18]
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   AST_VIRTUAL_TRAP: assert property ( // [RULE16]
      spr_valid && spr_req.num >= 8'ha0 |=> prot_trap_r && spr_ack_r)
      else $error("virtual special number did not trap");
   AST_USER_TRAP: assert property ( // [RULE15]
      spr_valid && user_mode && spr_req.num < 8'h80 |=> prot_trap_r)
      else $error("user access to protected special register did not trap");
   AST_UNPROT_OPEN: assert property ( // [RULE14]
      spr_valid && spr_req.num >= 8'h80 && spr_req.num <= 8'h9f |=> !prot_trap_r)
      else $error("unprotected special register trapped");
   AST_GLOBAL_DIRECT: assert property ( // [RULE2]
      rd_valid && !fields.src_a[7] && fields.src_a != 8'h00 |=> abs_r.src_a == $past(fields.src_a))
      else $error("global number was altered");
   AST_LOCAL_XLATE: assert property ( // [RULE6]
      rd_valid && fields.src_b[7] && fields.src_b != 8'h00
      |=> abs_r.src_b == {1'b1, 7'($past(fields.src_b[6:0]) + $past(sp_eff_r))})
      else $error("local translation wrong");
   AST_INDIRECT_DST: assert property ( // [RULE4]
      rd_valid && fields.dst == 8'h00 |=> abs_r.dst == $past(iptr_eff_r[0]))
      else $error("indirect destination not taken from pointer");
   AST_SP_NONARITH: assert property ( // [RULE7]
      wr_en && !wr_arith |=> $stable(shadow_sp_r))
      else $error("hidden stack pointer moved on non-arithmetic write");
   AST_SP_DELAY: assert property ( // [RULE8]
      wr_en && wr_arith && wr_abs == 8'h01 && $stable(shadow_sp_r)
      |=> sp_eff_r == $past(sp_eff_r) ##1
      sp_eff_r == $past(wr_data[8:2], 2))
      else $error("stack pointer reached translation at the wrong cycle");
   AST_IPTR_FIELD: assert property ( // [RULE19] [RULE12]
      spr_valid && spr_req.wr && !ip_set && spr_req.num == 8'h82 ##1
      !spr_valid && !ip_set ##1 spr_valid && !spr_req.wr && spr_req.num == 8'h82
      |=> spr_rdata_r == {22'h00_0000, $past(spr_req.data[9:2], 3), 2'b00})
      else $error("indirect pointer read back wrong");

   COV_INDIRECT_READ: cover property (rd_valid && fields.src_a == 8'h00);
   COV_LOCAL_WRAP: cover property (rd_valid && fields.src_a[7] &&
                                   (8'(fields.src_a[6:0]) + 8'(sp_eff_r)) > 8'h7f);
   COV_SP_UPDATE: cover property (wr_en && wr_arith && wr_abs == 8'h01);
   COV_USER_TRAP: cover property (spr_valid && user_mode && spr_req.num < 8'h80);

endmodule // rfa_regfile

`default_nettype wire

//--- bench/rfa_pipe_model.sv
// Decoder and pipeline model that issues requests to the register file.
`timescale 1ns/1ps
`default_nettype none

module rfa_pipe_model (
   // Clock.
   input wire logic core_clk,
   // Requests toward the register file.
   output logic rd_valid,
   output var rfa_pkg::rfa_fields_t fields,
   output logic user_mode,
   output logic wr_en,
   output logic [7:0] wr_abs,
   output logic [31:0] wr_data,
   output logic wr_arith,
   output logic ip_set,
   output var rfa_pkg::rfa_fields_t ip_vals,
   output logic spr_valid,
   output var rfa_pkg::rfa_spr_req_t spr_req,
   // Answers from the register file.
   input wire rfa_pkg::rfa_fields_t abs_r,
   input wire logic [31:0] rdata_a_r,
   input wire logic [31:0] rdata_b_r,
   input wire logic bank_trap_r,
   input wire logic spr_ack_r,
   input wire logic [31:0] spr_rdata_r,
   input wire logic prot_trap_r
);
   // ----------------------------------------------------------------
   // Request tasks, each entered just after a rising edge
   // ----------------------------------------------------------------
   // All request lines start idle.
   initial begin
      rd_valid = 1'b0;
      fields = '0;
      user_mode = 1'b0;
      wr_en = 1'b0;
      wr_abs = 8'h00;
      wr_data = 32'h0000_0000;
      wr_arith = 1'b0;
      ip_set = 1'b0;
      ip_vals = '0;
      spr_valid = 1'b0;
      spr_req = '0;
   end

   // Resolves three fields; the answer is sampled mid-cycle after the taking edge.
   task automatic rd_op(input rfa_pkg::rfa_fields_t f, input logic um,
                        output rfa_pkg::rfa_fields_t a, output logic [31:0] da,
                        output logic [31:0] db, output logic bt);
      rd_valid <= 1'b1;
      fields <= f;
      user_mode <= um;
      @(posedge core_clk);
      rd_valid <= 1'b0;
      @(negedge core_clk);
      a = abs_r;
      da = rdata_a_r;
      db = rdata_b_r;
      bt = bank_trap_r;
      @(posedge core_clk);
   endtask

   // Writes a result word; the ar input marks it as an arithmetic or logical result or not.
   task automatic wr_op(input logic [7:0] ab, input logic [31:0] d, input logic ar);
      wr_en <= 1'b1;
      wr_abs <= ab;
      wr_data <= d;
      wr_arith <= ar;
      @(posedge core_clk);
      wr_en <= 1'b0;
   endtask

   // Loads all three indirect pointers at once.
   task automatic ip_op(input rfa_pkg::rfa_fields_t v);
      ip_set <= 1'b1;
      ip_vals <= v;
      @(posedge core_clk);
      ip_set <= 1'b0;
   endtask

   // Moves to or from a special register and returns acknowledge, trap and data.
   task automatic spr_op(input logic w, input logic [7:0] n, input logic [31:0] d,
                         input logic um, output logic [33:0] ans);
      spr_valid <= 1'b1;
      spr_req <= {w, n, d};
      user_mode <= um;
      @(posedge core_clk);
      spr_valid <= 1'b0;
      @(negedge core_clk);
      ans = {spr_ack_r, prot_trap_r, spr_rdata_r};
      @(posedge core_clk);
   endtask
endmodule // rfa_pipe_model

`default_nettype wire

//--- bench/risc_register_file_addressing_tb.sv
// Self-checking testbench for the register file and its address logic.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin \
   n_checks++; \
   if ((got) !== (exp)) begin \
      fail_count++; \
      $display("wrong value at %0t ns: got %h expected %h", $time, (got), (exp)); \
   end \
end

module risc_register_file_addressing_tb;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic rd_valid, user_mode, wr_en, wr_arith, ip_set, spr_valid;
   logic [7:0] wr_abs;
   logic [31:0] wr_data, rdata_a_r, rdata_b_r, spr_rdata_r;
   logic bank_trap_r, spr_ack_r, prot_trap_r;
   rfa_pkg::rfa_fields_t fields, ip_vals, abs_r, a;
   rfa_pkg::rfa_spr_req_t spr_req;
   int fail_count = 0;
   int n_checks = 0;
   int cycles = 0;
   int i;
   logic [31:0] da, db;
   logic bt, tr, um;
   logic [33:0] ans;
   logic [7:0] n;
   logic [7:0] prot_nums [8] = '{8'h00, 8'h0c, 8'h7f, 8'h80, 8'h9f, 8'ha0, 8'ha2, 8'hff};

   // Design, and the pipeline model that drives it.
   rfa_regfile uut (.core_clk(core_clk), .sys_rst(sys_rst), .rd_valid(rd_valid),
      .fields(fields), .user_mode(user_mode), .wr_en(wr_en), .wr_abs(wr_abs),
      .wr_data(wr_data), .wr_arith(wr_arith), .ip_set(ip_set), .ip_vals(ip_vals),
      .spr_valid(spr_valid), .spr_req(spr_req), .abs_r(abs_r), .rdata_a_r(rdata_a_r),
      .rdata_b_r(rdata_b_r), .bank_trap_r(bank_trap_r), .spr_ack_r(spr_ack_r),
      .spr_rdata_r(spr_rdata_r), .prot_trap_r(prot_trap_r));
   rfa_pipe_model pm (.core_clk(core_clk), .rd_valid(rd_valid), .fields(fields),
      .user_mode(user_mode), .wr_en(wr_en), .wr_abs(wr_abs), .wr_data(wr_data),
      .wr_arith(wr_arith), .ip_set(ip_set), .ip_vals(ip_vals), .spr_valid(spr_valid),
      .spr_req(spr_req), .abs_r(abs_r), .rdata_a_r(rdata_a_r), .rdata_b_r(rdata_b_r),
      .bank_trap_r(bank_trap_r), .spr_ack_r(spr_ack_r), .spr_rdata_r(spr_rdata_r),
      .prot_trap_r(prot_trap_r));

   // The clock toggles every half period of 20 ns.
   always #20 core_clk = ~core_clk;

   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Cuts a hung run short.
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fail_count++;
         give_verdict();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      // Backed special registers reset to zero and keep a full word.
      for (i = 0; i < 18; i++) begin
         n = (i < 13) ? 8'(i) : 8'(i + 118);
         pm.spr_op(1'b0, n, 32'h0000_0000, 1'b0, ans);
         `CHK(ans, {2'b10, 32'h0000_0000})
         pm.spr_op(1'b1, n, 32'h5a5a_0000 | 32'(n), 1'b0, ans);
         pm.spr_op(1'b0, n, 32'h0000_0000, 1'b0, ans);
         `CHK(ans, {2'b10, 32'h5a5a_0000 | 32'(n)})
      end
      // Protection follows the number range and the mode.
      for (i = 0; i < 16; i++) begin
         n = prot_nums[i % 8];
         um = (i >= 8);
         tr = (n >= 8'ha0) || (um && n < 8'h80);
         pm.spr_op(1'b0, n, 32'h0000_0000, um, ans);
         `CHK(ans[33:32], {1'b1, tr})
         if (tr) `CHK(ans[31:0], 32'h0000_0000)
      end
      // Trapped writes store nothing; unbacked unprotected writes change nothing.
      pm.spr_op(1'b1, 8'h03, 32'hffff_ffff, 1'b1, ans);
      `CHK(ans[33:32], 2'b11)
      pm.spr_op(1'b1, 8'ha1, 32'hffff_ffff, 1'b0, ans);
      `CHK(ans[33:32], 2'b11)
      pm.spr_op(1'b1, 8'h88, 32'hffff_ffff, 1'b0, ans);
      `CHK(ans[33:32], 2'b10)
      pm.spr_op(1'b0, 8'h03, 32'h0000_0000, 1'b0, ans);
      `CHK(ans, {2'b10, 32'h5a5a_0003})
      pm.spr_op(1'b0, 8'h88, 32'h0000_0000, 1'b0, ans);
      `CHK(ans, {2'b10, 32'h0000_0000})

      // ----------------------------------------------------------------
      // General registers, stack pointer and indirect pointers
      // ----------------------------------------------------------------
      pm.spr_op(1'b1, 8'h07, 32'h0000_0002, 1'b0, ans);
      pm.wr_op(8'h40, 32'hc0de_0040, 1'b0);
      pm.rd_op({8'h40, 8'h05, 8'h02}, 1'b0, a, da, db, bt);
      `CHK({a, da, db, bt}, {24'h40_0502, 32'hc0de_0040, 32'h0000_0000, 1'b0})
      pm.rd_op({8'h40, 8'h12, 8'h41}, 1'b1, a, da, db, bt);
      `CHK(bt, 1'b1)
      pm.rd_op({8'h40, 8'h22, 8'h41}, 1'b1, a, da, db, bt);
      `CHK(bt, 1'b0)
      pm.wr_op(8'h01, 32'h0000_0010, 1'b1);
      pm.rd_op({8'h85, 8'h01, 8'hfe}, 1'b0, a, da, db, bt);
      `CHK({a, db}, {24'h85_01fe, 32'h0000_0010})
      pm.rd_op({8'h85, 8'h01, 8'hfe}, 1'b0, a, da, db, bt);
      `CHK(a, 24'h89_0182)
      // A non-arithmetic write moves global 1 but leaves the translation base alone.
      pm.wr_op(8'h01, 32'h0000_0200, 1'b0);
      @(posedge core_clk);
      pm.rd_op({8'h85, 8'h01, 8'hfe}, 1'b0, a, da, db, bt);
      `CHK({a, db}, {24'h89_0182, 32'h0000_0200})
      pm.wr_op(8'h89, 32'h1234_0089, 1'b0);
      pm.rd_op({8'h85, 8'h85, 8'h01}, 1'b0, a, da, db, bt);
      `CHK({da, db}, {32'h1234_0089, 32'h1234_0089})
      pm.ip_op({8'h89, 8'h40, 8'h85});
      @(posedge core_clk);
      pm.rd_op(24'h00_0000, 1'b0, a, da, db, bt);
      `CHK({a, da, db}, {24'h89_4085, 32'h1234_0089, 32'hc0de_0040})
      pm.spr_op(1'b1, 8'h82, 32'h0000_0fff, 1'b0, ans);
      pm.spr_op(1'b0, 8'h82, 32'h0000_0000, 1'b0, ans);
      `CHK(ans, {2'b10, 32'h0000_03fc})
      pm.rd_op(24'h00_0000, 1'b0, a, da, db, bt);
      `CHK(a.src_b, 8'hff)
      // The hardware pointer load shows up in a move from the pointer register.
      pm.spr_op(1'b0, 8'h81, 32'h0000_0000, 1'b1, ans);
      `CHK(ans, {2'b10, 32'h0000_0224})
      give_verdict();
   end
endmodule // risc_register_file_addressing_tb

`undef CHK
`default_nettype wire
